// *** rtl/ovsp_cmd_top.sv ***
// Operation
// - command 01001xxx sets the video standard; codes above PAL-N rejected
// - SECAM selection produces internal timing identical to PAL
// - external mode with SECAM routes the SECAM subcarrier input out
// - command 010100x0 bit 1 picks x4 multiplier or 4fsc crystal
// - x4 mode: divided LC clock compared with reference, error driven out
// - internal scan is non-interlaced, every field the same length
// - internal field: 263 lines NTSC/PAL-M, 312 lines PAL/PAL-N
// - position and address commands are taken as one two-byte unit
// - horizontal start is 16 dots plus 12 dots per step after hsync
// - vertical start is 9 lines per step after vsync
// - internal mode positions from the internal sync generator
// - external mode positions from sync separated out of composite sync
// - column field 5 bits, valid 0 to 23
// - line field 4 bits, valid 0 to 11
// - external mode without composite sync gives no reference, no display
`timescale 1ns/100ps
module ovsp_cmd_top (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // avalon-mm slave
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // pins
  input  wire logic             compositeSyncIn,
  input  wire logic             subcarrierRefIn,
  input  wire logic             lc4fscIn,
  input  wire logic             secamSubcarrierIn,
  output logic                  phaseErrorOut,
  output logic                  subcarrierOut,
  // timing to the display path
  output logic                  hRefOut,
  output logic                  vRefOut,
  output logic                  displayStartOut,
  output logic                  refValidOut,
  output ovsp_pkg::ovsp_cfg_t   cfgOut
);
  import ovsp_pkg::*;

  typedef enum logic {
    CMD_IDLE   = 1'b0,
    CMD_SECOND = 1'b1
  } ovsp_cmd_st_t;

  ovsp_cmd_st_t cmdSt_q;
  ovsp_cfg_t    cfg_q;
  logic         extMode_q;
  logic [7:0]   firstByte_q;
  logic         waitReq_q;
  logic [31:0]  rdata_q;
  logic         cmdStrobe;
  logic         ctrlStrobe;
  logic [7:0]   cmdByte;
  logic [15:0]  cmdWord;
  logic [1:0]   csync_q;
  logic [1:0]   fsc_q;
  logic [1:0]   lc_q;
  logic [1:0]   secam_q;
  logic         lcPrev_q;
  logic [1:0]   div_q;
  logic         phaseErr_q;
  logic         subcar_q;
  logic [9:0]   intHcnt_q;
  logic [8:0]   intLine_q;
  logic [8:0]   linesPerField;
  logic         intH;
  logic         intV;
  logic         sepH;
  logic         sepV;
  logic         hRef_q;
  logic         vRef_q;
  logic [9:0]   hpos_q;
  logic [8:0]   vline_q;
  logic [9:0]   hstart;
  logic [9:0]   vstart;
  logic         dispH_q;
  logic         dispV_q;
  logic         dispStart_q;
  logic [11:0]  refAge_q;
  logic         refValid_q;
  ovsp_status_t status;

  function automatic logic [8:0] field_lines(input ovsp_std_t s);
    unique case (s)
      STD_NTSC, STD_PALM: field_lines = LINES_525;
      default:            field_lines = LINES_625;
    endcase
  endfunction

  // slave answers one cycle after the request is first seen
  assign cmdStrobe  = avs_write && !waitReq_q && (avs_address == REG_CMD);
  assign ctrlStrobe = avs_write && !waitReq_q && (avs_address == REG_CTRL);
  assign cmdByte    = avs_writedata[7:0];
  assign cmdWord    = {firstByte_q, cmdByte};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitReq_q <= 1'b1;
    end else if (waitReq_q) begin
      waitReq_q <= !(avs_read || avs_write);
    end else begin
      waitReq_q <= 1'b1;
    end
  end

  always_comb begin
    status = '0;
    status.std             = cfg_q.std;
    status.osc             = cfg_q.osc;
    status.hstartStepField = cfg_q.hstartStepField;
    status.vstartStepField = cfg_q.vstartStepField;
    status.writeColAddr    = cfg_q.writeColAddr;
    status.writeLineAddr   = cfg_q.writeLineAddr;
    status.extMode         = extMode_q;
    status.refValid        = refValid_q;
    status.pending         = (cmdSt_q == CMD_SECOND);
  end

  // unmapped and write-only offsets read as zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && waitReq_q) begin
      unique case (avs_address)
        REG_CTRL:   rdata_q <= {31'h0000_0000, extMode_q};
        REG_STATUS: rdata_q <= status;
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      extMode_q <= CTRL_EXT_RST;
    end else if (ctrlStrobe) begin
      extMode_q <= avs_writedata[CTRL_EXT_BIT];
    end
  end

  // any byte after a two-byte opener is its second half
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdSt_q     <= CMD_IDLE;
      firstByte_q <= 8'h00;
    end else if (cmdStrobe) begin
      unique case (cmdSt_q)
        CMD_IDLE: begin
          if (cmdByte[7:4] == CMD_POS_HI || cmdByte[7:4] == CMD_ADDR_HI) begin
            cmdSt_q     <= CMD_SECOND;
            firstByte_q <= cmdByte;
          end
        end
        CMD_SECOND: cmdSt_q <= CMD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
    end else if (cmdStrobe && cmdSt_q == CMD_SECOND) begin
      if (firstByte_q[7:4] == CMD_POS_HI) begin
        cfg_q.hstartStepField <= cmdWord[POS_H_LSB +: 5];
        cfg_q.vstartStepField <= cmdWord[POS_V_LSB +: 5];
      end else if (cmdWord[ADR_COL_LSB +: 5] <= MAX_COL &&
                   cmdWord[ADR_LINE_LSB +: 4] <= MAX_LINE) begin
        cfg_q.writeColAddr  <= cmdWord[ADR_COL_LSB +: 5];
        cfg_q.writeLineAddr <= cmdWord[ADR_LINE_LSB +: 4];
      end
    end else if (cmdStrobe) begin
      if ((cmdByte & CMD_STD_MASK) == CMD_STD_OP &&
          cmdByte[2:0] <= STD_PALN) begin
        cfg_q.std <= ovsp_std_t'(cmdByte[2:0]);
      end
      if ((cmdByte & CMD_OSC_MASK) == CMD_OSC_OP) begin
        cfg_q.osc <= ovsp_osc_t'(cmdByte[OSC_BIT]);
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      csync_q <= 2'h3;
      fsc_q   <= 2'h0;
      lc_q    <= 2'h0;
      secam_q <= 2'h0;
    end else begin
      csync_q <= {csync_q[0], compositeSyncIn};
      fsc_q   <= {fsc_q[0], subcarrierRefIn};
      lc_q    <= {lc_q[0], lc4fscIn};
      secam_q <= {secam_q[0], secamSubcarrierIn};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lcPrev_q <= 1'b0;
      div_q    <= 2'h0;
    end else begin
      lcPrev_q <= lc_q[1];
      if (lc_q[1] && !lcPrev_q) begin
        div_q <= div_q + 2'h1;
      end
    end
  end

  // xor detector; its duty cycle is the phase error
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseErr_q <= 1'b0;
    end else if (cfg_q.osc == OSC_X4) begin
      phaseErr_q <= div_q[1] ^ fsc_q[1];
    end else begin
      phaseErr_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      subcar_q <= 1'b0;
    end else if (extMode_q && cfg_q.std == STD_SECAM) begin
      subcar_q <= secam_q[1];
    end else begin
      subcar_q <= div_q[1];
    end
  end

  // internal generator: same count every field, no half line
  assign linesPerField = field_lines(cfg_q.std);
  assign intH = (intHcnt_q == 10'h000);
  assign intV = intH && (intLine_q == 9'h000);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      intHcnt_q <= 10'h000;
      intLine_q <= 9'h000;
    end else if (intHcnt_q == LINE_DOTS - 10'h001) begin
      intHcnt_q <= 10'h000;
      if (intLine_q >= linesPerField - 9'h001) begin
        intLine_q <= 9'h000;
      end else begin
        intLine_q <= intLine_q + 9'h001;
      end
    end else begin
      intHcnt_q <= intHcnt_q + 10'h001;
    end
  end

  ovsp_sync_sep u_sep (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .csyncS  (csync_q[1]),
    .hEdge   (sepH),
    .vEdge   (sepV)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hRef_q <= 1'b0;
      vRef_q <= 1'b0;
    end else if (extMode_q) begin
      hRef_q <= sepH;
      vRef_q <= sepV;
    end else begin
      hRef_q <= intH;
      vRef_q <= intV;
    end
  end

  assign hstart = ovsp_step(cfg_q.hstartStepField, HSTEP_DOTS,
                            HSTART_BASE_DOTS);
  assign vstart = ovsp_step(cfg_q.vstartStepField, VSTEP_LINES, 5'h00);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hpos_q  <= 10'h000;
      vline_q <= 9'h000;
    end else begin
      if (hRef_q) begin
        hpos_q <= 10'h000;
      end else if (hpos_q != 10'h3ff) begin
        hpos_q <= hpos_q + 10'h001;
      end
      if (vRef_q) begin
        vline_q <= 9'h000;
      end else if (hRef_q && vline_q != 9'h1ff) begin
        vline_q <= vline_q + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dispH_q     <= 1'b0;
      dispV_q     <= 1'b0;
      dispStart_q <= 1'b0;
    end else begin
      // hstart never below 16; no wrap once hpos saturates
      dispH_q     <= !hRef_q && (hpos_q >= hstart - 10'h001);
      dispV_q     <= !vRef_q && ({1'b0, vline_q} >= vstart);
      dispStart_q <= dispH_q && dispV_q && refValid_q;
    end
  end

  // in external mode, losing composite sync drops the reference and with it the display
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      refAge_q   <= 12'h000;
      refValid_q <= 1'b0;
    end else begin
      if (hRef_q) begin
        refAge_q <= 12'h000;
      end else if (refAge_q != REF_TIMEOUT_DOTS) begin
        refAge_q <= refAge_q + 12'h001;
      end
      refValid_q <= (refAge_q != REF_TIMEOUT_DOTS);
    end
  end

  assign avs_waitrequest = waitReq_q;
  assign avs_readdata    = rdata_q;
  assign phaseErrorOut   = phaseErr_q;
  assign subcarrierOut   = subcar_q;
  assign hRefOut         = hRef_q;
  assign vRefOut         = vRef_q;
  assign displayStartOut = dispStart_q;
  assign refValidOut     = refValid_q;
  assign cfgOut          = cfg_q;

  property p_std_set;
    @(posedge sys_clk) disable iff (!rst_b)
    cmdStrobe && cmdSt_q == CMD_IDLE &&
    (cmdByte & CMD_STD_MASK) == CMD_STD_OP && cmdByte[2:0] <= 3'h4
    |=> cfg_q.std == $past(cmdByte[2:0]);
  endproperty
  a_std_set: assert property (p_std_set)
    else $error("standard code not taken");

  property p_std_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    cmdStrobe && cmdSt_q == CMD_IDLE &&
    (cmdByte & CMD_STD_MASK) == CMD_STD_OP && cmdByte[2:0] > 3'h4
    |=> $stable(cfg_q.std);
  endproperty
  a_std_hold: assert property (p_std_hold)
    else $error("prohibited standard code changed setting");

  property p_secam_pal;
    @(posedge sys_clk) disable iff (!rst_b)
    cfg_q.std == STD_SECAM || cfg_q.std == STD_PAL
    |-> linesPerField == 9'd312;
  endproperty
  a_secam_pal: assert property (p_secam_pal)
    else $error("SECAM or PAL field length wrong");

  property p_secam_sub;
    @(posedge sys_clk) disable iff (!rst_b)
    extMode_q && cfg_q.std == STD_SECAM |=> subcar_q == $past(secam_q[1]);
  endproperty
  a_secam_sub: assert property (p_secam_sub)
    else $error("SECAM subcarrier not routed");

  property p_osc_set;
    @(posedge sys_clk) disable iff (!rst_b)
    cmdStrobe && cmdSt_q == CMD_IDLE && (cmdByte & CMD_OSC_MASK) == CMD_OSC_OP
    |=> cfg_q.osc == $past(cmdByte[1]);
  endproperty
  a_osc_set: assert property (p_osc_set)
    else $error("oscillation method not taken");

  property p_phase;
    @(posedge sys_clk) disable iff (!rst_b)
    cfg_q.osc == OSC_X4 |=> phaseErr_q == $past(div_q[1] ^ fsc_q[1]);
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase error output wrong");

  property p_field_wrap;
    @(posedge sys_clk) disable iff (!rst_b)
    intLine_q == linesPerField - 9'd1 && intHcnt_q == LINE_DOTS - 10'd1
    |=> intLine_q == 9'd0 && intHcnt_q == 10'd0;
  endproperty
  a_field_wrap: assert property (p_field_wrap)
    else $error("internal field length wrong");

  property p_pair;
    @(posedge sys_clk) disable iff (!rst_b)
    cmdStrobe && cmdSt_q == CMD_SECOND |=> cmdSt_q == CMD_IDLE;
  endproperty
  a_pair: assert property (p_pair)
    else $error("second byte not closing the command");

  property p_addr_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    cmdStrobe && cmdSt_q == CMD_SECOND && firstByte_q[7:4] == CMD_ADDR_HI &&
    (cmdWord[8:4] > 5'd23 || cmdWord[3:0] > 4'd11)
    |=> $stable(cfg_q.writeColAddr) && $stable(cfg_q.writeLineAddr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("out-of-range write address taken");

  property p_hstart_gap;
    @(posedge sys_clk) disable iff (!rst_b)
    hRef_q |=> !dispH_q [*8];
  endproperty
  a_hstart_gap: assert property (p_hstart_gap)
    else $error("horizontal start too early after hsync");

  property p_vstart;
    @(posedge sys_clk) disable iff (!rst_b)
    vRef_q && cfg_q.vstartStepField != 5'd0 |=> !dispV_q [*2];
  endproperty
  a_vstart: assert property (p_vstart)
    else $error("vertical start at vsync with nonzero step");

  property p_ref_src;
    @(posedge sys_clk) disable iff (!rst_b)
    (extMode_q ? sepH : intH) |=> hRef_q;
  endproperty
  a_ref_src: assert property (p_ref_src)
    else $error("hsync reference from wrong source");

  property p_no_ref;
    @(posedge sys_clk) disable iff (!rst_b)
    !refValid_q |=> !dispStart_q;
  endproperty
  a_no_ref: assert property (p_no_ref)
    else $error("display started without reference");

endmodule

// *** rtl/ovsp_pkg.sv ***
package ovsp_pkg;

  // register map, byte addresses on the slave port
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int         CTRL_EXT_BIT = 0;
  localparam logic       CTRL_EXT_RST = 1'b0;

  // single-byte command opcodes
  localparam logic [7:0] CMD_STD_MASK = 8'hf8;
  localparam logic [7:0] CMD_STD_OP   = 8'h48;
  localparam logic [7:0] CMD_OSC_MASK = 8'hfd;
  localparam logic [7:0] CMD_OSC_OP   = 8'h50;
  localparam int         OSC_BIT      = 1;

  // two-byte commands, keyed on the upper nibble of the first byte
  localparam logic [3:0] CMD_POS_HI  = 4'h8;
  localparam logic [3:0] CMD_ADDR_HI = 4'ha;
  localparam int         POS_H_LSB   = 0;
  localparam int         POS_V_LSB   = 6;
  localparam int         ADR_LINE_LSB = 0;
  localparam int         ADR_COL_LSB  = 4;
  localparam logic [4:0] MAX_COL  = 5'h17;
  localparam logic [3:0] MAX_LINE = 4'hb;

  // timing in dot clocks or scan lines
  localparam logic [4:0] HSTART_BASE_DOTS = 5'h10;
  localparam logic [3:0] HSTEP_DOTS       = 4'hc;
  localparam logic [3:0] VSTEP_LINES      = 4'h9;
  localparam logic [8:0] LINES_525        = 9'h107;
  localparam logic [8:0] LINES_625        = 9'h138;
  localparam logic [9:0] LINE_DOTS        = 10'h280;
  localparam logic [8:0] VSEP_MIN_DOTS    = 9'h0c8;
  localparam logic [11:0] REF_TIMEOUT_DOTS = 12'h800;

  typedef enum logic [2:0] {
    STD_NTSC  = 3'h0,
    STD_PAL   = 3'h1,
    STD_PALM  = 3'h2,
    STD_SECAM = 3'h3,
    STD_PALN  = 3'h4
  } ovsp_std_t;

  typedef enum logic {
    OSC_X4      = 1'b0,
    OSC_CRYSTAL = 1'b1
  } ovsp_osc_t;

  typedef struct packed {
    ovsp_std_t  std;
    ovsp_osc_t  osc;
    logic [4:0] hstartStepField;
    logic [4:0] vstartStepField;
    logic [4:0] writeColAddr;
    logic [3:0] writeLineAddr;
  } ovsp_cfg_t;

  localparam ovsp_cfg_t CFG_RST = '{STD_NTSC, OSC_X4, 5'h00, 5'h00,
                                    5'h00, 4'h0};

  typedef struct packed {
    logic [5:0] pad;
    logic       pending;
    logic       refValid;
    logic       extMode;
    logic [3:0] writeLineAddr;
    logic [4:0] writeColAddr;
    logic [4:0] vstartStepField;
    logic [4:0] hstartStepField;
    ovsp_osc_t  osc;
    ovsp_std_t  std;
  } ovsp_status_t;

  function automatic logic [9:0] ovsp_step(input logic [4:0] n,
                                           input logic [3:0] unit,
                                           input logic [4:0] base);
    // widen before the product so no step is lost to a narrow multiply
    ovsp_step = 10'(n) * 10'(unit) + 10'(base);
  endfunction

endpackage

// *** rtl/ovsp_sync_sep.sv ***
`timescale 1ns/100ps
module ovsp_sync_sep (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // synchronised composite sync, low-going pulses
  input  wire logic csyncS,
  // separated references, one-cycle pulses
  output logic      hEdge,
  output logic      vEdge
);
  import ovsp_pkg::*;

  logic       prev_q;
  logic [8:0] lowCnt_q;
  logic       longSeen_q;
  logic       rise;

  assign rise = csyncS && !prev_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= csyncS;
    end
  end

  // low-width counter saturates so broad pulses stay classified
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_q <= 9'h000;
    end else if (csyncS) begin
      lowCnt_q <= 9'h000;
    end else if (lowCnt_q != 9'h1ff) begin
      lowCnt_q <= lowCnt_q + 9'h001;
    end
  end

  // only the first broad pulse of a vertical interval marks vsync
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hEdge      <= 1'b0;
      vEdge      <= 1'b0;
      longSeen_q <= 1'b0;
    end else begin
      hEdge <= rise && (lowCnt_q < VSEP_MIN_DOTS);
      vEdge <= rise && (lowCnt_q >= VSEP_MIN_DOTS) && !longSeen_q;
      if (rise) begin
        longSeen_q <= (lowCnt_q >= VSEP_MIN_DOTS);
      end
    end
  end

endmodule

// *** verification/osd_video_std_position_cmd_tb_top.sv ***
`timescale 1ns/100ps
module osd_video_std_position_cmd_tb_top;
  import ovsp_pkg::*;

  typedef struct packed {
    logic [1:0]  nBytes;
    logic [15:0] word;
    ovsp_cfg_t   exp;
  } ovsp_tb_row_t;

  logic         sys_clk;
  logic         rst_b;
  logic [3:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         compositeSyncIn;
  logic         subcarrierRefIn;
  logic         lc4fscIn;
  logic         secamSubcarrierIn;
  logic         phaseErrorOut;
  logic         subcarrierOut;
  logic         hRefOut;
  logic         vRefOut;
  logic         displayStartOut;
  logic         refValidOut;
  ovsp_cfg_t    cfgOut;
  logic         lcRun;
  logic         fscRun;
  logic [31:0]  q;
  int           nErrors;
  int           checkCount;
  int           cyc;
  int           d0;
  int           d1;
  ovsp_tb_row_t rows [15];

  ovsp_cmd_top dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .compositeSyncIn(compositeSyncIn), .subcarrierRefIn(subcarrierRefIn),
    .lc4fscIn(lc4fscIn), .secamSubcarrierIn(secamSubcarrierIn),
    .phaseErrorOut(phaseErrorOut), .subcarrierOut(subcarrierOut),
    .hRefOut(hRefOut), .vRefOut(vRefOut),
    .displayStartOut(displayStartOut), .refValidOut(refValidOut),
    .cfgOut(cfgOut));

  ovsp_host_model host (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // stand-in for the lc tank, sampled as data by the block
  always @(posedge sys_clk) begin
    if (lcRun) begin
      lc4fscIn <= ~lc4fscIn;
    end
    subcarrierRefIn <= fscRun && cyc[2];
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nErrors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sel 0: ones on phase error, sel 1: reference pulses
  task automatic cnt(input logic sel, input int n, output int ones);
    ones = 0;
    repeat (n) begin
      @(posedge sys_clk);
      ones += int'(sel ? hRefOut === 1'b1 : phaseErrorOut === 1'b1);
    end
  endtask

  // sel 0: line period, sel 1: delay from reference to start window
  // window may still stand from the last line, so wait for it to close
  task automatic gap(input logic sel, output int d);
    logic low;
    d = 0;
    while (hRefOut !== 1'b1 && d < 2000) begin
      @(posedge sys_clk);
      d++;
    end
    d = 0;
    low = !sel;
    do begin
      @(posedge sys_clk);
      d++;
      low = low || displayStartOut !== 1'b1;
    end while (!(low && (sel ? displayStartOut : hRefOut) === 1'b1) &&
               d < 2000);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    compositeSyncIn = 1'b1;
    subcarrierRefIn = 1'b0;
    lc4fscIn = 1'b0;
    secamSubcarrierIn = 1'b0;
    lcRun = 1'b0;
    fscRun = 1'b0;
    rows = '{'{2'h1, 16'h0049, 23'h100000}, '{2'h1, 16'h004a, 23'h200000},
      '{2'h1, 16'h004b, 23'h300000}, '{2'h1, 16'h004c, 23'h400000},
      '{2'h1, 16'h004d, 23'h400000}, '{2'h1, 16'h004f, 23'h400000},
      '{2'h1, 16'h0048, 23'h000000}, '{2'h1, 16'h0052, 23'h080000},
      '{2'h1, 16'h0050, 23'h000000}, '{2'h2, 16'h87df, 23'h07fe00},
      '{2'h2, 16'ha17b, 23'h07ff7b}, '{2'h2, 16'ha180, 23'h07ff7b},
      '{2'h2, 16'ha00c, 23'h07ff7b}, '{2'h2, 16'ha000, 23'h07fe00},
      '{2'h2, 16'h8002, 23'h008000}};
    repeat (2) @(posedge sys_clk);
    chk(32'(cfgOut), 32'h0);
    chk({31'h0, avs_waitrequest}, 32'h1);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].nBytes == 2'h2) begin
        host.cmd16(rows[i].word);
      end else begin
        host.wr8(rows[i].word[7:0]);
      end
      @(posedge sys_clk);
      chk(32'(cfgOut), 32'(rows[i].exp));
    end
    // opener then a byte that alone would be a standard command
    host.wr8(8'h80);
    host.xfer(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h03000020);
    host.wr8(8'h4b);
    host.xfer(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h010002b0);
    host.xfer(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    host.xfer(1'b0, REG_CMD, 32'h0, q);
    chk(q, 32'h0);
    gap(1'b0, d0);
    chk(32'(d0), 32'(LINE_DOTS));
    host.cmd16(16'h8000);
    gap(1'b1, d0);
    host.cmd16(16'h8003);
    gap(1'b1, d1);
    chk(32'(d1 - d0), 32'd36);
    lcRun <= 1'b1;
    fscRun <= 1'b1;
    cnt(1'b0, 64, d0);
    chk({31'h0, d0 > 0}, 32'h1);
    host.wr8(8'h52);
    fscRun <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cnt(1'b0, 64, d0);
    chk(32'(d0), 32'h0);
    host.wr8(8'h50);
    host.xfer(1'b1, REG_CTRL, 32'h1, q);
    host.xfer(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h1);
    host.wr8(8'h4b);
    secamSubcarrierIn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({31'h0, subcarrierOut}, 32'h1);
    secamSubcarrierIn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({31'h0, subcarrierOut}, 32'h0);
    // no composite sync: references must die out
    cnt(1'b1, 2300, d0);
    chk({31'h0, refValidOut}, 32'h0);
    cnt(1'b1, 100, d0);
    chk(32'(d0), 32'h0);
    compositeSyncIn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    compositeSyncIn <= 1'b1;
    cnt(1'b1, 12, d0);
    chk(32'(d0), 32'h1);
    // broad pulse gives vsync; one step of vertical start holds display
    host.cmd16(16'h8043);
    compositeSyncIn <= 1'b0;
    repeat (250) @(posedge sys_clk);
    compositeSyncIn <= 1'b1;
    d0 = 0;
    repeat (12) begin
      @(posedge sys_clk);
      d0 += int'(vRefOut === 1'b1);
    end
    chk(32'(d0), 32'h1);
    repeat (80) @(posedge sys_clk);
    chk({31'h0, displayStartOut}, 32'h0);
    host.cmd16(16'h8003);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, displayStartOut}, 32'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'(cfgOut), 32'h0);
    rst_b <= 1'b1;
    host.wr8(8'h49);
    @(posedge sys_clk);
    chk(32'(cfgOut), 32'h100000);
    complete_run();
  end
endmodule

// *** verification/ovsp_host_model.sv ***
`timescale 1ns/100ps
module ovsp_host_model (
  // clock
  input  wire logic        sys_clk,
  // avalon-mm master
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  import ovsp_pkg::*;

  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // released lines show inverted data so stale values never look valid
  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask

  task automatic wr8(input logic [7:0] b);
    logic [31:0] q;
    xfer(1'b1, REG_CMD, {24'h0, b}, q);
  endtask

  // both bytes always go out together, high byte first
  task automatic cmd16(input logic [15:0] w);
    wr8(w[15:8]);
    wr8(w[7:0]);
  endtask
endmodule
